// [pspll_pkg.sv]
// Shared constants and types of the synthesizer scan and phase-step controller
package pspll_pkg;
    localparam int SEG_NUM = 7;
    localparam int SEG_BITS = 18;
    localparam int CHAIN_LEN = 144;
    localparam int PUMP_POS = 126;
    localparam int LF_POS = 135;
    localparam int SCLK_DIV_DEF = 8;
    localparam logic [1:0] RUN_MIN = 2'h2;
    localparam logic [1:0] HOLD_MIN = 2'h2;
    localparam logic [7:0] DONE_WAIT = 8'hff;
    localparam logic [2:0] TGT_BAD = 3'h7;
    // Register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_LOOP = 8'h08;
    localparam logic [7:0] OFS_SEG0 = 8'h20;
    // Field positions
    localparam int CMD_SCAN_POS = 0;
    localparam int CMD_STEP_POS = 1;
    localparam int CMD_TGT_POS = 2;
    localparam int CMD_DIR_POS = 5;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_BAD_POS = 1;
    localparam int STAT_RUN_POS = 2;
    localparam int STAT_CS_POS = 3;
    localparam int STAT_SD_POS = 4;
    localparam int STAT_STEPS_POS = 16;
    localparam int LOOP_PUMP_POS = 0;
    localparam int LOOP_RES_POS = 8;
    localparam int LOOP_CAP_POS = 16;
    // Segment layout: low count, odd duty, high count, bypass
    localparam int SEG_ODD_POS = 8;
    localparam int SEG_BYP_POS = 17;
    localparam logic [SEG_BITS-1:0] SEG_RST = 18'h20000;
    localparam logic [2:0] PUMP_RST = 3'h0;
    localparam logic [4:0] RES_RST = 5'h00;
    localparam logic [1:0] CAP_RST = 2'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SC_ENA = 4'b0001,
        ST_SC_SHIFT = 4'b0010,
        ST_SC_UPD = 4'b0011,
        ST_SC_WAITHI = 4'b0100,
        ST_SC_WAITLO = 4'b0101,
        ST_PS_SET = 4'b0110,
        ST_PS_REQ = 4'b0111,
        ST_PS_WAITHI = 4'b1000,
        ST_PS_GAP = 4'b1001
    } pspll_state_t;
endpackage : pspll_pkg

// [pspll_clkdiv.sv]
// Configuration clock divider with rise and drive enables
`timescale 1ns/1ps
`default_nettype none
module pspll_clkdiv
    import pspll_pkg::*;
#(
    parameter int DIV = SCLK_DIV_DEF
) (
    input wire logic mclk,
    input wire logic rst_b,
    output logic scan_clk,
    output logic tick_rise,
    output logic tick_drive
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2);
    localparam logic [CW-1:0] MID = CW'(DIV / 4 - 1);

    if (DIV < 4 || DIV % 2 != 0) begin : g_bad_div
        $error("Divider must be even and at least four");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic clk;
    } pspll_div_t;

    pspll_div_t r_ff;
    pspll_div_t nxt_r;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.cnt = (r_ff.cnt == LAST) ? '0 : r_ff.cnt + 1'b1;
        nxt_r.clk = (nxt_r.cnt < HALF);
    end

    // Starts just before a rising edge so no edge is counted that never happened
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r_ff <= '{cnt: LAST, clk: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign scan_clk = r_ff.clk;
    assign tick_rise = (r_ff.cnt == '0);
    // Outputs move one cycle later, mid-high, far from both sampling edges
    assign tick_drive = (r_ff.cnt == MID);
endmodule : pspll_clkdiv
`default_nettype wire

// [pspll_ctrl.sv]
// Controller that loads the synthesizer scan chain and issues phase steps
`timescale 1ns/1ps
`default_nettype none
module pspll_ctrl
    import pspll_pkg::*;
#(
    parameter int SCLK_DIV = SCLK_DIV_DEF
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic scan_clk,
    output logic scan_clk_ena,
    output logic scan_data,
    output logic apply_chain_update,
    input wire logic scan_done,
    output logic shift_request,
    output logic shift_direction,
    output logic [2:0] shift_target_select,
    input wire logic shift_complete
);
    if (SCLK_DIV > 64) begin : g_bad_div
        $error("Configuration clock divider too large for the checks");
    end

    typedef struct packed {
        pspll_state_t st;
        logic [7:0] idx;
        logic [1:0] hold;
        logic [1:0] run;
        logic lo_seen;
        logic [SEG_NUM-1:0][SEG_BITS-1:0] seg;
        logic [2:0] pump;
        logic [4:0] res;
        logic [1:0] cap;
        logic [2:0] tgt;
        logic dir;
        logic bad;
        logic [15:0] steps;
        logic cs_m;
        logic cs_s;
        logic sd_m;
        logic sd_s;
        logic ena;
        logic sdata;
        logic upd;
        logic req;
        logic odir;
        logic [2:0] otgt;
        logic [31:0] rdata;
    } pspll_regs_t;

    pspll_regs_t r_ff;
    pspll_regs_t nxt_r;
    logic tick_rise;
    logic tick_drive;
    logic bad_set;
    logic [CHAIN_LEN-1:0] chain;

    pspll_clkdiv #(.DIV(SCLK_DIV)) u_div (
        .mclk(mclk),
        .rst_b(rst_b),
        .scan_clk(scan_clk),
        .tick_rise(tick_rise),
        .tick_drive(tick_drive)
    );

    function automatic logic [2:0] pump_enc(input logic [2:0] s);
        case (s)
            3'h1: pump_enc = 3'h4;
            3'h3: pump_enc = 3'h6;
            3'h7: pump_enc = 3'h7;
            default: pump_enc = 3'h0;
        endcase
    endfunction : pump_enc

    function automatic logic loop_ok(input logic [2:0] p, input logic [4:0] rr,
                                     input logic [1:0] c);
        logic pok;
        logic rok;
        pok = (p == 3'h0) || (p == 3'h1) || (p == 3'h3) || (p == 3'h7);
        case (rr)
            5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18, 5'h1b, 5'h1c,
            5'h1e: rok = 1'b1;
            default: rok = 1'b0;
        endcase
        loop_ok = pok && rok && (c != 2'h2);
    endfunction : loop_ok

    function automatic logic seg_hit(input logic [7:0] a);
        seg_hit = (a >= OFS_SEG0) && (a < OFS_SEG0 + 8'(4 * SEG_NUM)) && (a[1:0] == 2'h0);
    endfunction : seg_hit

    function automatic logic [2:0] seg_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_SEG0;
        seg_idx = d[4:2];
    endfunction : seg_idx

    // Segment 0 is the last output divider, so its low-count bit 0 goes first
    always_comb begin
        chain = '0;
        for (int k = 0; k < SEG_NUM; k++) begin
            chain[k*SEG_BITS +: SEG_BITS] = r_ff.seg[k];
        end
        chain[PUMP_POS +: 9] = {6'h00, pump_enc(r_ff.pump)};
        chain[LF_POS +: 9] = {r_ff.cap, r_ff.res, 2'h0};
    end

    always_comb begin
        nxt_r = r_ff;
        bad_set = 1'b0;
        nxt_r.cs_m = shift_complete;
        nxt_r.cs_s = r_ff.cs_m;
        nxt_r.sd_m = scan_done;
        nxt_r.sd_s = r_ff.sd_m;
        if (tick_rise && r_ff.run != RUN_MIN) begin
            nxt_r.run = r_ff.run + 2'h1;
        end
        if (reg_wr) begin
            case (reg_addr)
                OFS_CMD: begin
                    nxt_r.tgt = reg_wdata[CMD_TGT_POS +: 3];
                    nxt_r.dir = reg_wdata[CMD_DIR_POS];
                    // Commands while busy or before the clock runs are dropped
                    if (r_ff.st == ST_IDLE && r_ff.run == RUN_MIN) begin
                        if (reg_wdata[CMD_SCAN_POS]) begin
                            nxt_r.st = ST_SC_ENA;
                        end else if (reg_wdata[CMD_STEP_POS]) begin
                            if (reg_wdata[CMD_TGT_POS +: 3] == TGT_BAD) begin
                                bad_set = 1'b1;
                            end else begin
                                nxt_r.st = ST_PS_SET;
                            end
                        end
                    end
                end
                OFS_STAT: begin
                    if (reg_wdata[STAT_BAD_POS]) begin
                        nxt_r.bad = 1'b0;
                    end
                end
                OFS_LOOP: begin
                    if (!loop_ok(reg_wdata[LOOP_PUMP_POS +: 3], reg_wdata[LOOP_RES_POS +: 5],
                                 reg_wdata[LOOP_CAP_POS +: 2])) begin
                        bad_set = 1'b1;
                    end else if (r_ff.st == ST_IDLE) begin
                        nxt_r.pump = reg_wdata[LOOP_PUMP_POS +: 3];
                        nxt_r.res = reg_wdata[LOOP_RES_POS +: 5];
                        nxt_r.cap = reg_wdata[LOOP_CAP_POS +: 2];
                    end
                end
                default: begin
                    // Chain image is frozen while shifting to avoid a torn load
                    if (seg_hit(reg_addr) && r_ff.st == ST_IDLE) begin
                        nxt_r.seg[seg_idx(reg_addr)] = reg_wdata[SEG_BITS-1:0];
                    end
                end
            endcase
        end
        case (r_ff.st)
            ST_IDLE: begin
            end
            ST_SC_ENA: begin
                if (tick_drive) begin
                    nxt_r.ena = 1'b1;
                    nxt_r.idx = 8'h00;
                    nxt_r.st = ST_SC_SHIFT;
                end
            end
            ST_SC_SHIFT: begin
                if (tick_drive) begin
                    if (r_ff.idx == 8'(CHAIN_LEN)) begin
                        nxt_r.ena = 1'b0;
                        nxt_r.sdata = 1'b0;
                        nxt_r.upd = 1'b1;
                        nxt_r.st = ST_SC_UPD;
                    end else begin
                        nxt_r.sdata = chain[r_ff.idx];
                        nxt_r.idx = r_ff.idx + 8'h01;
                    end
                end
            end
            ST_SC_UPD: begin
                if (tick_drive) begin
                    nxt_r.upd = 1'b0;
                    nxt_r.idx = 8'h00;
                    nxt_r.st = ST_SC_WAITHI;
                end
            end
            ST_SC_WAITHI: begin
                // Give up after a bounded wait so a silent device cannot hang us
                if (r_ff.sd_s) begin
                    nxt_r.st = ST_SC_WAITLO;
                end else if (tick_drive) begin
                    nxt_r.idx = r_ff.idx + 8'h01;
                    if (r_ff.idx == DONE_WAIT) begin
                        nxt_r.st = ST_IDLE;
                    end
                end
            end
            ST_SC_WAITLO: begin
                if (!r_ff.sd_s) begin
                    nxt_r.st = ST_IDLE;
                end
            end
            ST_PS_SET: begin
                if (tick_drive && r_ff.cs_s) begin
                    nxt_r.odir = r_ff.dir;
                    nxt_r.otgt = r_ff.tgt;
                    nxt_r.lo_seen = 1'b0;
                    nxt_r.st = ST_PS_REQ;
                end
            end
            ST_PS_REQ: begin
                // A short completion low is latched; it may end within a cycle
                if (!r_ff.cs_s && r_ff.req) begin
                    nxt_r.lo_seen = 1'b1;
                end
                if (tick_drive) begin
                    if (!r_ff.req) begin
                        nxt_r.req = 1'b1;
                        nxt_r.hold = 2'h0;
                    end else if (r_ff.hold != HOLD_MIN) begin
                        nxt_r.hold = r_ff.hold + 2'h1;
                    end else if (r_ff.lo_seen) begin
                        nxt_r.req = 1'b0;
                        nxt_r.st = ST_PS_WAITHI;
                    end
                end
            end
            ST_PS_WAITHI: begin
                if (r_ff.cs_s) begin
                    nxt_r.steps = r_ff.steps + 16'h0001;
                    nxt_r.st = ST_PS_GAP;
                end
            end
            ST_PS_GAP: begin
                if (tick_drive) begin
                    nxt_r.st = ST_IDLE;
                end
            end
            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase
        if (bad_set) begin
            nxt_r.bad = 1'b1;
        end
        nxt_r.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CMD: begin
                    nxt_r.rdata[CMD_TGT_POS +: 3] = r_ff.tgt;
                    nxt_r.rdata[CMD_DIR_POS] = r_ff.dir;
                end
                OFS_STAT: begin
                    nxt_r.rdata[STAT_BUSY_POS] = (r_ff.st != ST_IDLE);
                    nxt_r.rdata[STAT_BAD_POS] = r_ff.bad;
                    nxt_r.rdata[STAT_RUN_POS] = (r_ff.run == RUN_MIN);
                    nxt_r.rdata[STAT_CS_POS] = r_ff.cs_s;
                    nxt_r.rdata[STAT_SD_POS] = r_ff.sd_s;
                    nxt_r.rdata[STAT_STEPS_POS +: 16] = r_ff.steps;
                end
                OFS_LOOP: begin
                    nxt_r.rdata[LOOP_PUMP_POS +: 3] = r_ff.pump;
                    nxt_r.rdata[LOOP_RES_POS +: 5] = r_ff.res;
                    nxt_r.rdata[LOOP_CAP_POS +: 2] = r_ff.cap;
                end
                default: begin
                    if (seg_hit(reg_addr)) begin
                        nxt_r.rdata[SEG_BITS-1:0] = r_ff.seg[seg_idx(reg_addr)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r_ff <= '0;
            r_ff.st <= ST_IDLE;
            r_ff.seg <= {SEG_NUM{SEG_RST}};
            r_ff.pump <= PUMP_RST;
            r_ff.res <= RES_RST;
            r_ff.cap <= CAP_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign reg_rdata = r_ff.rdata;
    assign scan_clk_ena = r_ff.ena;
    assign scan_data = r_ff.sdata;
    assign apply_chain_update = r_ff.upd;
    assign shift_request = r_ff.req;
    assign shift_direction = r_ff.odir;
    assign shift_target_select = r_ff.otgt;

    // Helper counters seen only by the checks below
    logic [7:0] hi_q;
    logic [7:0] gap_q;
    logic [7:0] upd_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hi_q <= 8'h00;
            gap_q <= 8'h00;
            upd_q <= 8'h00;
        end else begin
            hi_q <= r_ff.req ? ((hi_q == 8'hff) ? hi_q : hi_q + 8'h01) : 8'h00;
            gap_q <= r_ff.req ? 8'h00 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
            upd_q <= r_ff.upd ? upd_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_raise;
        $rose(r_ff.req);
    endsequence
    sequence s_drop;
        $fell(r_ff.req);
    endsequence

    req_hold_a: assert property (s_drop |-> $past(hi_q) >= 8'(2 * SCLK_DIV - 1))
        else $error("Step request held too short");
    req_gap_a: assert property (s_raise |-> gap_q >= 8'(SCLK_DIV))
        else $error("Step requests too close");
    drop_after_low_a: assert property (s_drop |-> $past(r_ff.lo_seen))
        else $error("Request dropped before completion went low");
    raise_when_done_a: assert property (s_raise |-> r_ff.cs_s && r_ff.run == RUN_MIN)
        else $error("Step started while busy or clock not running");
    sel_stable_a: assert property (r_ff.req |-> $stable(r_ff.odir) && $stable(r_ff.otgt))
        else $error("Direction or target moved during a step");
    req_on_tick_a: assert property ($changed(r_ff.req) |-> $past(tick_drive))
        else $error("Request changed off the drive point");
    upd_width_a: assert property ($fell(r_ff.upd) |-> $past(upd_q) == 8'(SCLK_DIV - 1))
        else $error("Update strobe not one clock cycle");
    chain_len_a: assert property ($rose(r_ff.upd) |-> $past(r_ff.idx) == 8'(CHAIN_LEN))
        else $error("Chain length wrong at update");
    upd_no_ena_a: assert property (r_ff.upd |-> !r_ff.ena)
        else $error("Update while shifting enabled");
    first_bit_a: assert property (r_ff.st == ST_SC_SHIFT && r_ff.idx == 8'h01
                                  |-> r_ff.sdata == r_ff.seg[0][0])
        else $error("First chain bit wrong");
    last_bit_a: assert property (r_ff.st == ST_SC_SHIFT && r_ff.idx == 8'(CHAIN_LEN)
                                 |-> r_ff.sdata == r_ff.cap[1])
        else $error("Last chain bit wrong");
    loop_legal_a: assert property (loop_ok(r_ff.pump, r_ff.res, r_ff.cap))
        else $error("Illegal loop setting stored");
endmodule : pspll_ctrl
`default_nettype wire

// [pspll_dev_model.sv]
// Behavioural model of the synthesizer's scan chain and phase-step logic
`timescale 1ns/1ps
`default_nettype none
module pspll_dev_model #(
    parameter realtime PER = 160
) (
    input wire logic scan_clk,
    input wire logic scan_clk_ena,
    input wire logic scan_data,
    input wire logic apply_chain_update,
    output logic scan_done,
    input wire logic shift_request,
    input wire logic shift_direction,
    input wire logic [2:0] shift_target_select,
    output logic shift_complete,
    input wire logic slow
);
    logic [143:0] shreg;
    logic [143:0] chain;
    logic skip = 1'b1;
    logic was_hi = 1'b0;
    logic dir_q;
    logic [2:0] tgt_q;
    int nbits = 0;
    int steps = 0;
    int viol = 0;
    int hi_cnt = 0;
    int tap[0:5] = '{default: 0};
    realtime fell_t = -1000;

    initial begin
        scan_done = 1'b0;
        shift_complete = 1'b1;
    end

    // Segment factor: bypass wins, other bits ignored
    function automatic int factor(input logic [17:0] s);
        return s[17] ? 1 : int'(s[16:9]) + int'(s[7:0]);
    endfunction : factor

    // First enabled edge is only the set-up cycle
    always @(posedge scan_clk) begin
        if (scan_clk_ena !== 1'b1) begin
            skip = 1'b1;
        end else if (skip) begin
            skip = 1'b0;
        end else begin
            shreg = {scan_data, shreg[143:1]};
            nbits++;
        end
        if (shift_request === 1'b1) hi_cnt++;
    end

    always @(posedge scan_clk) begin
        if (apply_chain_update === 1'b1) begin
            chain = shreg;
            scan_done = 1'b1;
            repeat (2) @(posedge scan_clk);
            scan_done = 1'b0;
        end
    end

    // Controller-side faults are counted, not tolerated
    always @(posedge shift_request) begin
        if (shift_complete !== 1'b1 || $realtime - fell_t < PER) viol++;
        hi_cnt = 0;
        was_hi = 1'b1;
    end

    always @(negedge shift_request) begin
        if (was_hi && hi_cnt < 2) viol++;
        was_hi = 1'b0;
        fell_t = $realtime;
    end

    always begin
        @(negedge scan_clk iff shift_request === 1'b1);
        @(posedge scan_clk);
        @(posedge scan_clk);
        dir_q = shift_direction;
        tgt_q = shift_target_select;
        shift_complete = 1'b0;
        steps++;
        for (int i = 0; i < 6; i++) begin
            if (tgt_q == 3'h0 ? i > 0 : i == int'(tgt_q) - 1) tap[i] += dir_q ? 1 : -1;
        end
        // Low time deliberately shorter or longer than a cycle
        #(slow ? 3 * PER : PER / 4) shift_complete = 1'b1;
        wait (shift_request !== 1'b1);
    end
endmodule : pspll_dev_model
`default_nettype wire

// [testbench.sv]
// Register-level testbench of the scan and phase-step controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pspll_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    logic [2:0] sel;
    wire logic scan_clk, scan_clk_ena, scan_data, apply_chain_update, scan_done;
    wire logic shift_request, shift_direction, shift_complete;
    int mismatches = 0;
    int comparisons = 0;
    logic [31:0] res_ok[11] = '{0, 3, 4, 8, 16, 19, 20, 24, 27, 28, 30};
    logic [31:0] pump_ok[4] = '{0, 1, 3, 7};
    logic [31:0] bad_loop[3] = '{32'h2, 32'h500, 32'h20000};

    always #10 mclk = ~mclk;

    pspll_ctrl #(.SCLK_DIV(8)) DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scan_clk(scan_clk), .scan_clk_ena(scan_clk_ena), .scan_data(scan_data),
        .apply_chain_update(apply_chain_update), .scan_done(scan_done),
        .shift_request(shift_request), .shift_direction(shift_direction),
        .shift_target_select(sel), .shift_complete(shift_complete));

    pspll_dev_model #(.PER(160)) dev (.scan_clk(scan_clk), .scan_clk_ena(scan_clk_ena),
        .scan_data(scan_data), .apply_chain_update(apply_chain_update), .scan_done(scan_done),
        .shift_request(shift_request), .shift_direction(shift_direction),
        .shift_target_select(sel), .shift_complete(shift_complete), .slow(slow));

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic put(input logic [7:0] a, input logic [31:0] v);
        wr(a, v);
        rd(a, d);
        chk("readback", d, v);
    endtask : put

    task automatic wait_stat(input int pos, input logic v);
        int i;
        for (i = 0; i < 4000; i++) begin
            rd(OFS_STAT, d);
            if (d[pos] === v) break;
        end
        if (i == 4000) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : wait_stat

    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        wr(OFS_CMD, 32'h2);
        wait_stat(STAT_RUN_POS, 1'b1);
        chk("early_cmd", d, 32'h0000000c);
        rd(OFS_LOOP, d);
        chk("loop_reset", d, 32'h0);
        rd(OFS_SEG0 + 8'h18, d);
        chk("seg6_reset", d, 32'h20000);
        rd(8'h10, d);
        chk("unmapped", d, 32'h0);
        foreach (res_ok[i]) put(OFS_LOOP, res_ok[i] << 8);
        foreach (pump_ok[i]) put(OFS_LOOP, pump_ok[i]);
        for (int c = 0; c < 4; c++) if (c != 2) put(OFS_LOOP, 32'(c) << 16);
        put(OFS_LOOP, 32'h31303);
        foreach (bad_loop[i]) begin
            wr(OFS_LOOP, bad_loop[i]);
            rd(OFS_STAT, d);
            chk("bad_flag", 32'(d[STAT_BAD_POS]), 32'h1);
            rd(OFS_LOOP, d);
            chk("loop_kept", d, 32'h31303);
            wr(OFS_STAT, 32'h2);
        end
        put(OFS_SEG0, 32'h01505);
        wr(OFS_CMD, 32'h1);
        wait_stat(STAT_BUSY_POS, 1'b1);
        wr(OFS_LOOP, 32'h7);
        wait_stat(STAT_BUSY_POS, 1'b0);
        chk("bits", 32'(dev.nbits), 32'd144);
        chk("seg0", 32'(dev.chain[17:0]), 32'h01505);
        chk("seg6", 32'(dev.chain[125:108]), 32'h20000);
        chk("tail", 32'(dev.chain[143:126]), 32'h39806);
        chk("fac0", 32'(dev.factor(dev.chain[17:0])), 32'd15);
        chk("fac6", 32'(dev.factor(dev.chain[125:108])), 32'd1);
        rd(OFS_LOOP, d);
        chk("busy_wr", d, 32'h31303);
        for (int t = 0; t < 7; t++) begin
            slow <= (t > 3);
            wr(OFS_CMD, 32'(2 | (t << 2) | ((t & 1) << 5)));
            wait_stat(STAT_BUSY_POS, 1'b1);
            wait_stat(STAT_BUSY_POS, 1'b0);
            chk("target", 32'(dev.tgt_q), 32'(t));
            chk("dir", 32'(dev.dir_q), 32'(t & 1));
            chk("steps", 32'(dev.steps), 32'(t + 1));
        end
        rd(OFS_STAT, d);
        chk("step_cnt", 32'(d[31:16]), 32'd7);
        chk("stat_end", d, 32'h0007000c);
        chk("fb_tap", 32'(dev.tap[0]), 32'd1);
        chk("out0_tap", 32'(dev.tap[1]), 32'hfffffffe);
        chk("viol", 32'(dev.viol), 32'd0);
        wr(OFS_CMD, 32'h1e);
        rd(OFS_STAT, d);
        chk("tgt7_flag", 32'(d[STAT_BAD_POS]), 32'h1);
        rd(OFS_CMD, d);
        chk("cmd_fields", d, 32'h0000001c);
        repeat (200) @(posedge mclk);
        chk("tgt7_steps", 32'(dev.steps), 32'd7);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
